// ### core/adcsq_defines.vh
`ifndef ADCSQ_DEFINES_VH
`define ADCSQ_DEFINES_VH

// Register indices; the byte address is four times the index.
`define ADCSQ_IDX_TRIG_CTRL 5'h02
`define ADCSQ_IDX_FMT_SEQ 5'h03
`define ADCSQ_IDX_START 5'h05
`define ADCSQ_IDX_STATUS 5'h06
`define ADCSQ_IDX_CCF 5'h07
`define ADCSQ_IDX_CMP_EN 5'h08
`define ADCSQ_IDX_IRQ_STAT 5'h09
`define ADCSQ_IDX_IRQ_MASK 5'h0a
`define ADCSQ_IDX_RESULT0 5'h10
`define ADCSQ_IDX_RESULT7 5'h17

// Trigger control fields.
`define ADCSQ_TRIG_LE_BIT 4
`define ADCSQ_TRIG_POL_BIT 3
`define ADCSQ_TRIG_EN_BIT 2
`define ADCSQ_CMP_IRQ_EN_BIT 0

// Format and sequence control fields.
`define ADCSQ_JUSTIFY_BIT 7
`define ADCSQ_SEQ_MSB 6
`define ADCSQ_SEQ_LSB 3
`define ADCSQ_FIFO_BIT 2
`define ADCSQ_HALT_MSB 1
`define ADCSQ_HALT_LSB 0
`define ADCSQ_FMT_SEQ_RESET 8'h20

// Start register fields.
`define ADCSQ_SCAN_BIT 5

// Interrupt status and mask fields.
`define ADCSQ_IRQ_SEQ_BIT 0
`define ADCSQ_IRQ_CMP_BIT 1

// Debug halt selections.
`define ADCSQ_HALT_FINISH 2'h2
`define ADCSQ_HALT_NOW 2'h3

// Sequence lengths.
`define ADCSQ_SEQ_MAX 4'h8

// Bus responses.
`define ADCSQ_RESP_OKAY 2'h0
`define ADCSQ_RESP_SLVERR 2'h2

`endif

// ### core/adcsq_trig.v
`timescale 1ns/1ps
`default_nettype none

// Turns the external trigger pin into a start request of the chosen kind.
module adcsq_trig (
  input wire aclk,
  input wire aresetn,
  input wire trig_in,
  input wire trig_level_edge_sel,
  input wire trig_polarity_sel,
  output wire trig_fire
);

  reg prev_reg;

  // Previous pin value, for edge detection.
  always @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= trig_in;
    end
  end

  // Edge modes give a one-cycle pulse; level modes stay high while active.
  assign trig_fire = trig_level_edge_sel ?
    (trig_in == trig_polarity_sel) :
    (trig_polarity_sel ? (trig_in & ~prev_reg) : (~trig_in & prev_reg));

endmodule // adcsq_trig

`default_nettype wire

// ### core/adcsq_top.v
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_defines.vh"

module adcsq_top (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire ext_trig_in,
  input wire stop_mode,
  input wire debug_freeze,
  input wire conv_done,
  input wire [11:0] conv_data,
  output wire conv_start,
  output wire conv_abort,
  output wire conv_hold,
  output wire irq
);

  localparam ST_IDLE = 2'h0;
  localparam ST_ISSUE = 2'h1;
  localparam ST_WAIT = 2'h2;

  // Bus slave state.
  reg aw_have_reg;
  reg [4:0] aw_idx_reg;
  reg aw_ok_reg;
  reg w_have_reg;
  reg [7:0] wdata_reg;
  reg w_lane_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0] rresp_reg;

  // Software registers.
  reg [7:0] trig_ctrl_reg;
  reg [7:0] fmt_seq_reg;
  reg scan_reg;
  reg [7:0] compare_en_per_conv_reg;
  reg [7:0] conv_complete_flag_reg;
  reg [1:0] irq_stat_reg;
  reg [1:0] irq_mask_reg;
  reg [15:0] result_mem [0:7];

  // Sequencer state.
  reg [1:0] state_reg;
  reg [2:0] seq_cnt_reg;
  reg [2:0] conv_counter_reg;
  reg armed_reg;
  reg conv_start_reg;
  reg conv_abort_reg;
  reg conv_hold_reg;

  wire trig_fire;
  wire result_justify_sel = fmt_seq_reg[`ADCSQ_JUSTIFY_BIT];
  wire [3:0] seq_field = fmt_seq_reg[`ADCSQ_SEQ_MSB:`ADCSQ_SEQ_LSB];
  wire fifo_mode = fmt_seq_reg[`ADCSQ_FIFO_BIT];
  wire [1:0] debug_halt_sel = fmt_seq_reg[`ADCSQ_HALT_MSB:`ADCSQ_HALT_LSB];
  wire ext_trig_en = trig_ctrl_reg[`ADCSQ_TRIG_EN_BIT];
  wire compare_irq_en = trig_ctrl_reg[`ADCSQ_CMP_IRQ_EN_BIT];

  // Zero and every code with the top bit set mean a full sequence of eight.
  wire [3:0] seq_len = (seq_field[3] || seq_field == 4'h0) ?
    `ADCSQ_SEQ_MAX : seq_field;
  wire [2:0] seq_last = seq_len[2:0] - 3'h1;

  // Code 01 falls through to "keep converting" with 00.
  wire halt_now = debug_freeze && (debug_halt_sel == `ADCSQ_HALT_NOW);
  wire halt_next = debug_freeze &&
    (debug_halt_sel == `ADCSQ_HALT_FINISH || halt_now);

  // Write decode happens once both address and data are held.
  wire wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
  wire wr_en = wr_fire && aw_ok_reg && w_lane_reg;
  wire wr_trig = wr_en && (aw_idx_reg == `ADCSQ_IDX_TRIG_CTRL);
  wire wr_fmt = wr_en && (aw_idx_reg == `ADCSQ_IDX_FMT_SEQ);
  wire wr_start = wr_en && (aw_idx_reg == `ADCSQ_IDX_START);
  wire wr_ccf = wr_en && (aw_idx_reg == `ADCSQ_IDX_CCF);
  wire wr_cmp = wr_en && (aw_idx_reg == `ADCSQ_IDX_CMP_EN);
  wire wr_istat = wr_en && (aw_idx_reg == `ADCSQ_IDX_IRQ_STAT);
  wire wr_imask = wr_en && (aw_idx_reg == `ADCSQ_IDX_IRQ_MASK);

  // A result lands only while a conversion is outstanding and not aborted.
  wire result_take = (state_reg == ST_WAIT) && conv_done && !wr_fmt &&
    !wr_start;
  wire seq_end = result_take && (seq_cnt_reg == seq_last);
  wire restart = seq_end && scan_reg && !ext_trig_en;
  // Trigger is ignored in stop mode, since the bus clock is not trusted.
  wire trig_start = ext_trig_en && trig_fire && armed_reg && !stop_mode &&
    (state_reg == ST_IDLE) && !wr_fmt && !wr_start;

  // Automatic compare is masked off completely in FIFO mode.
  wire cmp_event = result_take && !fifo_mode && compare_irq_en &&
    compare_en_per_conv_reg[conv_counter_reg];

  wire [15:0] justified = result_justify_sel ?
    {4'h0, conv_data} : {conv_data, 4'h0};

  function mapped;
    input [4:0] idx;
    begin
      mapped = (idx == `ADCSQ_IDX_TRIG_CTRL) || (idx == `ADCSQ_IDX_FMT_SEQ) ||
        (idx == `ADCSQ_IDX_START) || (idx == `ADCSQ_IDX_STATUS) ||
        (idx == `ADCSQ_IDX_CCF) || (idx == `ADCSQ_IDX_CMP_EN) ||
        (idx == `ADCSQ_IDX_IRQ_STAT) || (idx == `ADCSQ_IDX_IRQ_MASK) ||
        (idx >= `ADCSQ_IDX_RESULT0 && idx <= `ADCSQ_IDX_RESULT7);
    end
  endfunction

  adcsq_trig u_trig (
    .aclk(aclk),
    .aresetn(aresetn),
    .trig_in(ext_trig_in),
    .trig_level_edge_sel(trig_ctrl_reg[`ADCSQ_TRIG_LE_BIT]),
    .trig_polarity_sel(trig_ctrl_reg[`ADCSQ_TRIG_POL_BIT]),
    .trig_fire(trig_fire)
  );

  // Write channel: address and data are taken in either order.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      aw_idx_reg <= 5'h00;
      aw_ok_reg <= 1'b0;
      w_have_reg <= 1'b0;
      wdata_reg <= 8'h00;
      w_lane_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `ADCSQ_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_idx_reg <= s_axi_awaddr[6:2];
        aw_ok_reg <= mapped(s_axi_awaddr[6:2]) && !s_axi_awaddr[7];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata[7:0];
        w_lane_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= aw_ok_reg ? `ADCSQ_RESP_OKAY : `ADCSQ_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready = !w_have_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // Read data mux; only the low sixteen bits ever carry data.
  reg [15:0] rd_mux;
  wire [4:0] ar_idx = s_axi_araddr[6:2];
  always @* begin
    rd_mux = 16'h0000;
    case (ar_idx)
      `ADCSQ_IDX_TRIG_CTRL: rd_mux = {8'h00, trig_ctrl_reg};
      `ADCSQ_IDX_FMT_SEQ: rd_mux = {8'h00, fmt_seq_reg};
      `ADCSQ_IDX_START: rd_mux = {10'h000, scan_reg, 5'h00};
      `ADCSQ_IDX_STATUS: rd_mux = {8'h00, state_reg != ST_IDLE,
        conv_hold_reg, 1'b0, armed_reg, 1'b0, conv_counter_reg};
      `ADCSQ_IDX_CCF: rd_mux = {8'h00, conv_complete_flag_reg};
      `ADCSQ_IDX_CMP_EN: rd_mux = {8'h00, compare_en_per_conv_reg};
      `ADCSQ_IDX_IRQ_STAT: rd_mux = {14'h0000, irq_stat_reg};
      `ADCSQ_IDX_IRQ_MASK: rd_mux = {14'h0000, irq_mask_reg};
      default: begin
        if (ar_idx >= `ADCSQ_IDX_RESULT0 && ar_idx <= `ADCSQ_IDX_RESULT7) begin
          rd_mux = result_mem[ar_idx[2:0]];
        end
      end
    endcase
  end

  // Read channel: one read at a time, answered one cycle after the address.
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `ADCSQ_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {16'h0000, rd_mux};
      rresp_reg <= (mapped(ar_idx) && !s_axi_araddr[7]) ?
        `ADCSQ_RESP_OKAY : `ADCSQ_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // Plain control registers.
  always @(posedge aclk) begin
    if (!aresetn) begin
      trig_ctrl_reg <= 8'h00;
      fmt_seq_reg <= `ADCSQ_FMT_SEQ_RESET;
      scan_reg <= 1'b0;
      compare_en_per_conv_reg <= 8'h00;
      irq_mask_reg <= 2'h0;
    end else begin
      if (wr_trig) begin
        trig_ctrl_reg <= {3'h0, wdata_reg[4:2], 1'b0, wdata_reg[0]};
      end
      if (wr_fmt) begin
        fmt_seq_reg <= wdata_reg;
      end
      if (wr_start) begin
        scan_reg <= wdata_reg[`ADCSQ_SCAN_BIT];
      end
      if (wr_cmp) begin
        compare_en_per_conv_reg <= wdata_reg;
      end
      if (wr_imask) begin
        irq_mask_reg <= wdata_reg[1:0];
      end
    end
  end

  // Sticky flags: a set in the same cycle as a clear wins.
  wire [7:0] ccf_set = result_take ? (8'h01 << conv_counter_reg) : 8'h00;
  wire [7:0] ccf_clr = (wr_ccf ? wdata_reg : 8'h00) |
    (wr_start ? 8'hff : 8'h00);
  wire [1:0] istat_set = {cmp_event, seq_end};
  wire [1:0] istat_clr = wr_istat ? wdata_reg[1:0] : 2'h0;
  always @(posedge aclk) begin
    if (!aresetn) begin
      conv_complete_flag_reg <= 8'h00;
      irq_stat_reg <= 2'h0;
    end else begin
      conv_complete_flag_reg <= (conv_complete_flag_reg & ~ccf_clr) |
        ccf_set;
      irq_stat_reg <= (irq_stat_reg & ~istat_clr) | istat_set;
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // Result file; stored at the counter position in both modes.
  always @(posedge aclk) begin
    if (result_take) begin
      result_mem[conv_counter_reg] <= justified;
    end
  end

  // Sequencer. Abort takes priority over any result arriving that cycle.
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      seq_cnt_reg <= 3'h0;
      conv_counter_reg <= 3'h0;
      armed_reg <= 1'b0;
      conv_start_reg <= 1'b0;
      conv_abort_reg <= 1'b0;
      conv_hold_reg <= 1'b0;
    end else begin
      conv_start_reg <= 1'b0;
      conv_abort_reg <= 1'b0;
      conv_hold_reg <= halt_now && (state_reg == ST_WAIT) && !wr_fmt &&
        !wr_start;
      if (wr_fmt) begin
        state_reg <= ST_IDLE;
        seq_cnt_reg <= 3'h0;
        conv_counter_reg <= 3'h0;
        conv_abort_reg <= (state_reg != ST_IDLE);
      end else if (wr_start) begin
        armed_reg <= 1'b1;
        seq_cnt_reg <= 3'h0;
        conv_counter_reg <= 3'h0;
        conv_abort_reg <= (state_reg != ST_IDLE);
        state_reg <= ext_trig_en ? ST_IDLE : ST_ISSUE;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (trig_start) begin
              state_reg <= ST_ISSUE;
              seq_cnt_reg <= 3'h0;
              if (!fifo_mode) begin
                conv_counter_reg <= 3'h0;
              end
            end
          end
          ST_ISSUE: begin
            // Hold off the next conversion while the debugger has us halted.
            if (!halt_next) begin
              conv_start_reg <= 1'b1;
              state_reg <= ST_WAIT;
            end
          end
          ST_WAIT: begin
            if (result_take) begin
              // Three-bit counter wraps naturally after register seven.
              conv_counter_reg <= conv_counter_reg + 3'h1;
              if (seq_end) begin
                seq_cnt_reg <= 3'h0;
                state_reg <= restart ? ST_ISSUE : ST_IDLE;
                if (restart && !fifo_mode) begin
                  conv_counter_reg <= 3'h0;
                end
              end else begin
                seq_cnt_reg <= seq_cnt_reg + 3'h1;
                state_reg <= ST_ISSUE;
              end
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  assign conv_start = conv_start_reg;
  assign conv_abort = conv_abort_reg;
  assign conv_hold = conv_hold_reg;

endmodule // adcsq_top

`default_nettype wire

// ### sim/adcsq_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_defines.vh"

// Watches the bus handshakes and converter strobes of the top module.
module adcsq_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic debug_freeze,
  input wire logic conv_start,
  input wire logic conv_abort,
  input wire logic conv_hold
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic unm_reg;

  // Remembers whether the accepted write address has bit 7 set, which puts it outside the map.
  always @(posedge aclk) begin
    if (!aresetn) begin
      unm_reg <= 1'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      unm_reg <= s_axi_awaddr[7];
    end
  end

  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  write_refuse_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken early");
  read_refuse_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready wrong");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read not answered");
  unmapped_resp_a: assert property (s_axi_bvalid && unm_reg |->
    s_axi_bresp == `ADCSQ_RESP_SLVERR) else $error("no error response");
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("start too long");
  abort_pulse_a: assert property (conv_abort |=> !conv_abort)
    else $error("abort too long");
  hold_cause_a: assert property (conv_hold |-> debug_freeze ||
    $past(debug_freeze) || $past(debug_freeze, 2)) else $error("bad hold");
endmodule // adcsq_props
`default_nettype wire

// ### sim/adcsq_conv_model.sv
`timescale 1ns/1ps
`default_nettype none

// Stands in for the converter: answers each start after a random delay, unless an abort cancels it first.
module adcsq_conv_model (
  input wire logic aclk,
  input wire logic conv_start,
  input wire logic conv_abort,
  input wire logic conv_hold,
  output logic conv_done = 1'h0,
  output logic [11:0] conv_data = 12'h0
);
  logic busy = 1'h0;
  int wait_cnt = 0;

  // Data toggles whenever no result is offered, so a stale sample fails.
  always @(posedge aclk) begin
    conv_done <= 1'h0;
    conv_data <= ~conv_data;
    if (conv_abort) begin
      busy <= 1'h0;
    end else if (conv_start) begin
      busy <= 1'h1;
      wait_cnt <= $urandom_range(0, 6);
    end else if (busy && !conv_hold) begin
      if (wait_cnt == 0) begin
        busy <= 1'h0;
        conv_done <= 1'h1;
        conv_data <= 12'($urandom);
      end else begin
        wait_cnt <= wait_cnt - 1;
      end
    end
  end
endmodule // adcsq_conv_model
`default_nettype wire

// ### sim/adc_sequence_result_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_defines.vh"
// Compares a seen value with the expected one and counts the outcome.
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  n_fail++; $display("BAD %s exp %h got %h", nm, e, g); end end

module adc_sequence_result_control_tb;
  logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0, ext_trig_in = 1'h0, stop_mode = 1'h0;
  logic debug_freeze = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, conv_done, conv_start, conv_abort;
  logic conv_hold, irq;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, f;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [11:0] conv_data, logv [0:7];
  int n_fail = 0, comparisons = 0, nconv = 0, cyc = 0, n0;

  adcsq_top u_adcsq_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ext_trig_in, .stop_mode, .debug_freeze, .conv_done, .conv_data,
    .conv_start, .conv_abort, .conv_hold, .irq);
  adcsq_conv_model u_adcsq_conv_model (.aclk, .conv_start, .conv_abort,
    .conv_hold, .conv_done, .conv_data);

  // A 40 ns clock.
  always #20 aclk = ~aclk;

  // Logs delivered results by slot and cuts a hung run short.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (conv_done) begin
      logv[nconv[2:0]] <= conv_data;
      nconv <= nconv + 1;
    end
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  function automatic logic [7:0] ad(input logic [4:0] i);
    return {1'h0, i, 2'h0};
  endfunction

  function automatic int len_f(input logic [3:0] c);
    return (c == 4'h0 || c[3]) ? 8 : c;
  endfunction

  function automatic logic [31:0] just_f(input logic rj, logic [11:0] d);
    return rj ? {20'h0, d} : {16'h0, d, 4'h0};
  endfunction

  // The response ready may start low, so slow masters are exercised too.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit a_ok, w_ok, got;
    @(posedge aclk);
    {a_ok, w_ok} = 2'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'($urandom_range(0, 1));
    while (!(a_ok && w_ok)) begin
      @(negedge aclk);
      a_ok |= s_axi_awready;
      w_ok |= s_axi_wready;
      @(posedge aclk);
      if (a_ok) s_axi_awvalid <= 1'h0;
      if (w_ok) s_axi_wvalid <= 1'h0;
    end
    do begin
      @(negedge aclk);
      got = s_axi_bvalid && s_axi_bready;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (!got) s_axi_bready <= 1'h1;
    end while (!got);
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a);
    bit got;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'($urandom_range(0, 1));
    do begin
      @(negedge aclk);
      got = s_axi_arready;
      @(posedge aclk);
    end while (!got);
    s_axi_arvalid <= 1'h0;
    do begin
      @(negedge aclk);
      got = s_axi_rvalid && s_axi_rready;
      rd_d = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (!got) s_axi_rready <= 1'h1;
    end while (!got);
    s_axi_rready <= 1'h0;
  endtask

  task automatic chk_res(input int cnt, input logic rj);
    for (int k = 0; k < cnt; k++) begin
      rd(ad(5'(`ADCSQ_IDX_RESULT0 + k)));
      `CHK("result", just_f(rj, logv[k]), rd_d)
    end
  endtask

  // Reset, every length code, FIFO wrap with a halt, then each trigger mode.
  initial begin
    void'($urandom(32'h14ed));
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    rd(ad(`ADCSQ_IDX_FMT_SEQ));
    `CHK("fmt_reset", {24'h0, `ADCSQ_FMT_SEQ_RESET}, rd_d)
    rd(8'hfc);
    `CHK("unmapped_rd", `ADCSQ_RESP_SLVERR, rsp)
    wr(8'hfc, 32'hff);
    `CHK("unmapped_wr", `ADCSQ_RESP_SLVERR, rsp)
    wr(ad(`ADCSQ_IDX_TRIG_CTRL), 32'h1);
    wr(ad(`ADCSQ_IDX_CMP_EN), 32'h1);
    wr(ad(`ADCSQ_IDX_IRQ_MASK), 32'h1);
    debug_freeze <= 1'h1;
    for (int i = 0; i < 16; i++) begin
      f = {1'($urandom_range(0, 1)), i[3:0], 2'h0, i[0]};
      wr(ad(`ADCSQ_IDX_FMT_SEQ), {24'h0, f});
      rd(ad(`ADCSQ_IDX_FMT_SEQ));
      `CHK("fmt_rw", {24'h0, f}, rd_d)
      wr(ad(`ADCSQ_IDX_START), 32'h0);
      nconv = 0;
      do rd(ad(`ADCSQ_IDX_IRQ_STAT)); while (rd_d[0] !== 1'h1);
      `CHK("irq_stat", 32'h3, rd_d)
      `CHK("irq_on", 1'h1, irq)
      `CHK("n_conv", len_f(i[3:0]), nconv)
      rd(ad(`ADCSQ_IDX_STATUS));
      `CHK("counter", 3'(len_f(i[3:0])), rd_d[2:0])
      rd(ad(`ADCSQ_IDX_CCF));
      `CHK("ccf", 32'((1 << len_f(i[3:0])) - 1), rd_d)
      chk_res(len_f(i[3:0]), f[7]);
      wr(ad(`ADCSQ_IDX_IRQ_STAT), 32'h1);
      `CHK("irq_masked", 1'h0, irq)
      wr(ad(`ADCSQ_IDX_IRQ_STAT), 32'h2);
    end
    wr(ad(`ADCSQ_IDX_CMP_EN), 32'hff);
    wr(ad(`ADCSQ_IDX_FMT_SEQ), {24'h0, 1'h1, 4'h3, 1'h1, `ADCSQ_HALT_NOW});
    debug_freeze <= 1'h0;
    wr(ad(`ADCSQ_IDX_START), 32'h20);
    nconv = 0;
    while (nconv < 11) @(posedge aclk);
    debug_freeze <= 1'h1;
    repeat (4) @(posedge aclk);
    n0 = nconv;
    repeat (20) @(posedge aclk);
    `CHK("frozen", n0, nconv)
    rd(ad(`ADCSQ_IDX_STATUS));
    `CHK("fifo_cnt", 3'(nconv), rd_d[2:0])
    rd(ad(`ADCSQ_IDX_IRQ_STAT));
    `CHK("no_compare", 1'h0, rd_d[1])
    chk_res(8, 1'h1);
    wr(ad(`ADCSQ_IDX_FMT_SEQ), 32'h1e);
    rd(ad(`ADCSQ_IDX_STATUS));
    `CHK("aborted", 4'h0, {rd_d[7], rd_d[2:0]})
    // Halt code 10: the conversion in flight lands, then nothing new starts.
    debug_freeze <= 1'h0;
    wr(ad(`ADCSQ_IDX_START), 32'h20);
    nconv = 0;
    while (nconv < 5) @(posedge aclk);
    debug_freeze <= 1'h1;
    repeat (12) @(posedge aclk);
    n0 = nconv;
    repeat (20) @(posedge aclk);
    `CHK("finish_frz", n0, nconv)
    rd(ad(`ADCSQ_IDX_STATUS));
    `CHK("finish_cnt", 3'(nconv), rd_d[2:0])
    `CHK("no_hold", 1'h0, rd_d[6])
    debug_freeze <= 1'h0;
    for (int m = 0; m < 4; m++) begin
      ext_trig_in <= !m[0];
      wr(ad(`ADCSQ_IDX_FMT_SEQ), 32'h08);
      wr(ad(`ADCSQ_IDX_TRIG_CTRL), {27'h0, m[1], m[0], 1'h1, 2'h0});
      wr(ad(`ADCSQ_IDX_START), 32'h0);
      repeat (30) @(posedge aclk);
      nconv = 0;
      stop_mode <= 1'h1;
      ext_trig_in <= m[0];
      repeat (30) @(posedge aclk);
      `CHK("stop_trig", 0, nconv)
      stop_mode <= 1'h0;
      ext_trig_in <= !m[0];
      repeat (30) @(posedge aclk);
      nconv = 0;
      ext_trig_in <= m[0];
      repeat (30) @(posedge aclk);
      `CHK("trig", 1'h1, m[1] ? nconv > 1 : nconv == 1)
    end
    report_and_stop();
  end
endmodule // adc_sequence_result_control_tb

bind adcsq_top adcsq_props u_adcsq_props (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .debug_freeze, .conv_start, .conv_abort, .conv_hold);
`default_nettype wire
